// ---- rtl/rsc_pkg.sv ----
// shared constants, types and register map of the relay setpoint controller
`default_nettype none
package rsc_pkg;
  // register word offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFF_CFG0 = 8'h00;
  localparam logic [7:0] OFF_HIGH0 = 8'h04;
  localparam logic [7:0] OFF_LOW0 = 8'h08;
  localparam logic [7:0] OFF_CFG1 = 8'h10;
  localparam logic [7:0] OFF_HIGH1 = 8'h14;
  localparam logic [7:0] OFF_LOW1 = 8'h18;
  localparam logic [7:0] OFF_DEADBAND = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  // config word fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_HEN_BIT = 4;
  localparam int CFG_LEN_BIT = 5;
  localparam int CFG_SRC_LSB = 8;
  // temperature in millikelvin, unsigned
  localparam int TEMP_W = 20;
  localparam logic [19:0] DEADBAND_RST = 20'h0_00FA; // 0.250 K
  localparam logic [19:0] SETPT_RST = 20'h0_0000;
  localparam int NUM_CH = 2;
  localparam int SRC_W = 3;

  // relay operating modes
  typedef enum logic [2:0]
  {
    RSC_OFF = 3'h0,
    RSC_ON = 3'h1,
    RSC_AUTO = 3'h2,
    RSC_WITHIN = 3'h3,
    RSC_CTRL = 3'h4
  } rsc_mode_t;

  // status codes
  typedef enum logic [1:0]
  {
    RSC_ST_CLEAR = 2'h0,
    RSC_ST_HIGH = 2'h1,
    RSC_ST_LOW = 2'h2,
    RSC_ST_ON = 2'h3
  } rsc_status_t;

  // per-channel settings carried as one bundle
  typedef struct packed
  {
    logic [2:0] src;
    logic hi_en;
    logic lo_en;
    rsc_mode_t mode;
    logic [19:0] high;
    logic [19:0] low;
  } rsc_chcfg_t;
endpackage
`default_nettype wire

// ---- rtl/rsc_relay_ch.sv ----
// one relay channel: hysteresis flags, mode selection and status code
`timescale 1ns/1ns
`default_nettype none
module rsc_relay_ch #(
  parameter int TW = rsc_pkg::TEMP_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire rsc_pkg::rsc_chcfg_t cfg,
  input wire logic [TW-1:0] deadband,
  input wire logic [TW-1:0] temp,
  input wire logic temp_valid,
  input wire logic sample_stb,
  input wire logic ctrl_active,
  output logic relay,
  output rsc_pkg::rsc_status_t status,
  output logic hi_flag,
  output logic lo_flag
);
  initial
  begin
    if (TW < 4)
      $error("temperature width too small");
    if (TW != rsc_pkg::TEMP_W)
      $error("temperature width must match the settings bundle");
  end

  // ===========================================================
  // hysteresis thresholds, widened by one bit against wrap
  logic [TW:0] t_w;
  logic [TW:0] hi_set;
  logic [TW:0] hi_rst;
  logic [TW:0] lo_set;
  logic [TW:0] lo_rst;
  logic hi_q;
  logic hi_d;
  logic lo_q;
  logic lo_d;
  assign t_w = {1'b0, temp};
  assign hi_set = {1'b0, cfg.high} + {1'b0, deadband};
  assign hi_rst = ({1'b0, cfg.high} >= {1'b0, deadband}) ?
                  ({1'b0, cfg.high} - {1'b0, deadband}) : '0;
  assign lo_set = ({1'b0, cfg.low} >= {1'b0, deadband}) ?
                  ({1'b0, cfg.low} - {1'b0, deadband}) : '0;
  assign lo_rst = {1'b0, cfg.low} + {1'b0, deadband};

  // next condition flags, a disabled limit holds its flag clear
  assign hi_d = !cfg.hi_en ? 1'b0 :
                (t_w > hi_set) ? 1'b1 :
                (t_w <= hi_rst) ? 1'b0 : hi_q;
  assign lo_d = !cfg.lo_en ? 1'b0 :
                (t_w <= lo_set) ? 1'b1 :
                (t_w >= lo_rst) ? 1'b0 : lo_q;

  // flags advance only on a fresh temperature sample
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end
    else if (sample_stb)
    begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  // ===========================================================
  // mode selection from the stored flags
  logic out_of_lim;
  logic relay_d;
  rsc_pkg::rsc_status_t st_d;
  assign out_of_lim = hi_q | lo_q;
  always_comb
  begin
    relay_d = 1'b0;
    st_d = rsc_pkg::RSC_ST_CLEAR;
    case (cfg.mode)
      rsc_pkg::RSC_AUTO:
      begin
        relay_d = out_of_lim;
        st_d = hi_q ? rsc_pkg::RSC_ST_HIGH :
               (lo_q ? rsc_pkg::RSC_ST_LOW : rsc_pkg::RSC_ST_CLEAR);
      end
      rsc_pkg::RSC_WITHIN:
      begin
        relay_d = !out_of_lim && temp_valid;
        st_d = relay_d ? rsc_pkg::RSC_ST_ON : rsc_pkg::RSC_ST_CLEAR;
      end
      rsc_pkg::RSC_ON:
      begin
        relay_d = 1'b1;
        st_d = rsc_pkg::RSC_ST_ON;
      end
      rsc_pkg::RSC_CTRL:
      begin
        relay_d = ctrl_active;
        st_d = ctrl_active ? rsc_pkg::RSC_ST_ON : rsc_pkg::RSC_ST_CLEAR;
      end
      default:
      begin
        relay_d = 1'b0;
        st_d = rsc_pkg::RSC_ST_CLEAR;
      end
    endcase
  end

  // registered relay and status outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      relay <= 1'b0;
      status <= rsc_pkg::RSC_ST_CLEAR;
    end
    else
    begin
      relay <= relay_d;
      status <= st_d;
    end
  end
  assign hi_flag = hi_q;
  assign lo_flag = lo_q;

  // ===========================================================
  // checks
  AST_ON_HOLDS: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg.mode == rsc_pkg::RSC_ON |=> relay)
    else $error("relay not asserted in on mode");
  AST_OFF_HOLDS: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg.mode == rsc_pkg::RSC_OFF |=> !relay)
    else $error("relay asserted in off mode");
  AST_WITHIN_INVALID: assert property (@(posedge ref_clk)
    disable iff (!arst_n)
    cfg.mode == rsc_pkg::RSC_WITHIN && !temp_valid |=> !relay)
    else $error("within relay set on invalid reading");
  AST_CTRL_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg.mode == rsc_pkg::RSC_CTRL |=> relay == $past(ctrl_active))
    else $error("control relay does not follow regulator");
  AST_HI_DISABLED: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !cfg.hi_en && sample_stb |=> !hi_q)
    else $error("disabled high limit set its flag");
  AST_HI_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sample_stb && cfg.hi_en && t_w > hi_set |=> hi_q)
    else $error("high condition missed");
  AST_HI_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !sample_stb |=> $stable(hi_q) && $stable(lo_q))
    else $error("flag changed without sample");
  AST_LO_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sample_stb && cfg.lo_en && t_w <= lo_set |=> lo_q)
    else $error("low condition missed");
  AST_LO_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sample_stb && t_w >= lo_rst && t_w > lo_set |=> !lo_q)
    else $error("low condition not cleared");
  AST_AUTO_HIGH: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg.mode == rsc_pkg::RSC_AUTO && hi_q |=>
    relay && status == rsc_pkg::RSC_ST_HIGH)
    else $error("auto high not reported");
  COV_AUTO_HIGH: cover property (@(posedge ref_clk)
    cfg.mode == rsc_pkg::RSC_AUTO && hi_q ##1 relay);
  COV_AUTO_LOW: cover property (@(posedge ref_clk)
    cfg.mode == rsc_pkg::RSC_AUTO && lo_q ##1 relay);
  COV_WITHIN: cover property (@(posedge ref_clk)
    cfg.mode == rsc_pkg::RSC_WITHIN ##1 relay);
endmodule
`default_nettype wire

// ---- rtl/rsc_top.sv ----
// relay setpoint controller: register file, interrupts, two relay channels
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - two independent relays, each picking any temperature input as source.
// - auto mode asserts when above enabled high or below enabled low.
// - separate high and low setpoints and enables; disabled limits ignored.
// - high sets above setpoint plus deadband, clears at setpoint minus it.
// - low sets at setpoint minus deadband, clears at setpoint plus it.
// - within mode is the complement of auto, asserting inside the window.
// - within mode also needs a valid reading; invalid clears the relay.
// - on mode holds the relay asserted unconditionally.
// - off mode holds the relay cleared unconditionally.
// - control mode follows the regulator's actively-regulating report.
// - status reports clear, high, low, or on while on, within or control mode asserts the relay.
// - each relay lights its own led exactly while asserted.
module rsc_top #(
  parameter int NUM_IN = 8,
  parameter int TW = rsc_pkg::TEMP_W
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NUM_IN*TW-1:0] temp_in,
  input wire logic [NUM_IN-1:0] temp_valid,
  input wire logic sample_stb,
  input wire logic ctrl_active,
  output logic [1:0] relay_out,
  output logic [1:0] relay_led,
  output logic irq
);
  initial
  begin
    if (NUM_IN < 1 || NUM_IN > 8)
      $error("input count must be 1 to 8");
    if (TW != rsc_pkg::TEMP_W)
      $error("temperature width must match package");
  end

  localparam int NCH = rsc_pkg::NUM_CH;

  // ===========================================================
  // register storage
  rsc_pkg::rsc_chcfg_t cfg_q [NCH];
  logic [TW-1:0] deadband_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [31:0] rdata_q;

  // write decode, per channel and for the shared registers
  logic [NCH-1:0] wr_cfg;
  logic [NCH-1:0] wr_high;
  logic [NCH-1:0] wr_low;
  logic wr_db;
  logic wr_istat;
  logic wr_imask;
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_dec
      localparam logic [7:0] BASE = 8'(g * rsc_pkg::CH_STRIDE);
      assign wr_cfg[g] = reg_wr && reg_addr == rsc_pkg::OFF_CFG0 + BASE;
      assign wr_high[g] = reg_wr && reg_addr == rsc_pkg::OFF_HIGH0 + BASE;
      assign wr_low[g] = reg_wr && reg_addr == rsc_pkg::OFF_LOW0 + BASE;
    end
  endgenerate
  assign wr_db = reg_wr && reg_addr == rsc_pkg::OFF_DEADBAND;
  assign wr_istat = reg_wr && reg_addr == rsc_pkg::OFF_IRQ_STAT;
  assign wr_imask = reg_wr && reg_addr == rsc_pkg::OFF_IRQ_MASK;

  // per-channel settings; mode writes name the relay by its offset
  generate
    for (g = 0; g < NCH; g++)
    begin : g_cfg
      always_ff @(posedge ref_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cfg_q[g].src <= 3'(g);
          cfg_q[g].hi_en <= 1'b0;
          cfg_q[g].lo_en <= 1'b0;
          cfg_q[g].mode <= rsc_pkg::RSC_OFF;
          cfg_q[g].high <= rsc_pkg::SETPT_RST;
          cfg_q[g].low <= rsc_pkg::SETPT_RST;
        end
        else
        begin
          if (wr_cfg[g])
          begin
            cfg_q[g].mode <= rsc_pkg::rsc_mode_t'(
              reg_wdata[rsc_pkg::CFG_MODE_LSB +: 3]);
            cfg_q[g].hi_en <= reg_wdata[rsc_pkg::CFG_HEN_BIT];
            cfg_q[g].lo_en <= reg_wdata[rsc_pkg::CFG_LEN_BIT];
            cfg_q[g].src <= reg_wdata[rsc_pkg::CFG_SRC_LSB +: 3];
          end
          if (wr_high[g])
            cfg_q[g].high <= reg_wdata[TW-1:0];
          if (wr_low[g])
            cfg_q[g].low <= reg_wdata[TW-1:0];
        end
      end
    end
  endgenerate

  // shared deadband
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      deadband_q <= rsc_pkg::DEADBAND_RST;
    else if (wr_db)
      deadband_q <= reg_wdata[TW-1:0];
  end

  // ===========================================================
  // relay channels
  logic [NCH-1:0] relay_w;
  logic [NCH-1:0] hi_w;
  logic [NCH-1:0] lo_w;
  rsc_pkg::rsc_status_t st_w [NCH];
  logic [TW-1:0] src_temp [NCH];
  logic [NCH-1:0] src_valid;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      // source mux, out-of-range source reads as invalid zero
      assign src_temp[g] = (cfg_q[g].src < NUM_IN) ?
        temp_in[cfg_q[g].src * TW +: TW] : '0;
      assign src_valid[g] = (cfg_q[g].src < NUM_IN) ?
        temp_valid[cfg_q[g].src] : 1'b0;
      rsc_relay_ch #(
        .TW(TW)
      ) u_ch (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .cfg(cfg_q[g]),
        .deadband(deadband_q),
        .temp(src_temp[g]),
        .temp_valid(src_valid[g]),
        .sample_stb(sample_stb),
        .ctrl_active(ctrl_active),
        .relay(relay_w[g]),
        .status(st_w[g]),
        .hi_flag(hi_w[g]),
        .lo_flag(lo_w[g])
      );
    end
  endgenerate
  assign relay_out = relay_w;
  assign relay_led = relay_w;

  // ===========================================================
  // interrupts: bit per channel for assert and release edges
  logic [NCH-1:0] relay_prev_q;
  logic [3:0] irq_ev;
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      relay_prev_q <= '0;
    else
      relay_prev_q <= relay_w;
  end
  assign irq_ev = {relay_prev_q & ~relay_w, relay_w & ~relay_prev_q};

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~(wr_istat ? reg_wdata[3:0] : 4'h0))
                    | irq_ev;
      if (wr_imask)
        irq_mask_q <= reg_wdata[3:0];
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ===========================================================
  // read mux, unmapped addresses read zero
  logic [31:0] rd_mux;
  logic [31:0] cfg_rd [NCH];
  logic [31:0] st_rd;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_rd
      assign cfg_rd[g] = {21'h00_0000, cfg_q[g].src, 2'h0,
                          cfg_q[g].lo_en, cfg_q[g].hi_en, 1'h0,
                          cfg_q[g].mode};
    end
  endgenerate
  assign st_rd = {16'h0000, 2'h0, lo_w[1], hi_w[1], 2'h0, lo_w[0], hi_w[0],
                  2'h0, relay_w[1], relay_w[0], st_w[1], st_w[0]};
  assign rd_mux =
    (reg_addr == rsc_pkg::OFF_CFG0) ? cfg_rd[0] :
    (reg_addr == rsc_pkg::OFF_HIGH0) ? {12'h000, cfg_q[0].high} :
    (reg_addr == rsc_pkg::OFF_LOW0) ? {12'h000, cfg_q[0].low} :
    (reg_addr == rsc_pkg::OFF_CFG1) ? cfg_rd[1] :
    (reg_addr == rsc_pkg::OFF_HIGH1) ? {12'h000, cfg_q[1].high} :
    (reg_addr == rsc_pkg::OFF_LOW1) ? {12'h000, cfg_q[1].low} :
    (reg_addr == rsc_pkg::OFF_DEADBAND) ? {12'h000, deadband_q} :
    (reg_addr == rsc_pkg::OFF_STATUS) ? st_rd :
    (reg_addr == rsc_pkg::OFF_IRQ_STAT) ? {28'h000_0000, irq_stat_q} :
    (reg_addr == rsc_pkg::OFF_IRQ_MASK) ? {28'h000_0000, irq_mask_q} :
    32'h0000_0000;

  // read data valid the cycle after the strobe only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata = rdata_q;

  // ===========================================================
  // checks
  AST_LED_MATCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
    relay_led == relay_out)
    else $error("led differs from relay");
  AST_MODE_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_cfg[0] && reg_wdata[2:0] == 3'h1 |=> ##1 relay_out[0])
    else $error("on command not applied");
  AST_IRQ_STICKY: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_ev[0] |=> irq_stat_q[0])
    else $error("assert event lost");
  COV_REMOTE_ON: cover property (@(posedge ref_clk)
    wr_cfg[1] ##2 relay_out[1]);
  COV_IRQ: cover property (@(posedge ref_clk) irq);
endmodule
`default_nettype wire

// ---- test/rsc_actuator.sv ----
// far-side model: contactors driven by the two relay outputs
`timescale 1ns/1ns
`default_nettype none
module rsc_actuator (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [1:0] relay_out,
  output logic [1:0] engaged
);
  // contacts follow the coil one cycle late, open while in reset
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      engaged <= 2'h0;
    else
      engaged <= relay_out;
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench of the relay setpoint controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  // ==========================================================
  // signals and instances
  typedef struct packed
  {
    rsc_pkg::rsc_mode_t mode;
    logic [1:0] en;
    logic [19:0] temp;
    logic vld;
    logic ctl;
    logic rly;
    rsc_pkg::rsc_status_t st;
  } rsc_row_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [159:0] temp_in = '0;
  logic [7:0] temp_valid = 8'hFF;
  logic sample_stb = 1'b0;
  logic ctrl_active = 1'b0;
  logic [1:0] relay_out;
  logic [1:0] relay_led;
  logic irq;
  logic [1:0] engaged;
  logic [31:0] rd_q;
  int n_mismatch = 0;
  int n_tests = 0;
  rsc_row_t rows [18];
  rsc_top rsc_top_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .temp_in(temp_in),
    .temp_valid(temp_valid), .sample_stb(sample_stb),
    .ctrl_active(ctrl_active), .relay_out(relay_out),
    .relay_led(relay_led), .irq(irq));
  rsc_actuator rsc_actuator_inst (.ref_clk(ref_clk), .arst_n(arst_n),
    .relay_out(relay_out), .engaged(engaged));
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  // ==========================================================
  // bus and sample tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // present a reading on input i, pulse the strobe, let relay settle
  task automatic sample(input int i, input logic [19:0] t);
    @(posedge ref_clk);
    temp_in[i*20+:20] <= t;
    sample_stb <= 1'b1;
    @(posedge ref_clk);
    sample_stb <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    rows[0] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h4_93E0, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[1] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h5_0A0A, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[2] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h5_0A0B, 3'h5, rsc_pkg::RSC_ST_HIGH};
    rows[3] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h5_0817, 3'h5, rsc_pkg::RSC_ST_HIGH};
    rows[4] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h5_0816, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[5] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h3_CF97, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[6] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h3_CF96, 3'h5, rsc_pkg::RSC_ST_LOW};
    rows[7] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h3_D189, 3'h5, rsc_pkg::RSC_ST_LOW};
    rows[8] = {rsc_pkg::RSC_AUTO, 2'h3, 20'h3_D18A, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[9] = {rsc_pkg::RSC_AUTO, 2'h0, 20'h5_3020, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[10] = {rsc_pkg::RSC_AUTO, 2'h2, 20'h5_3020, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[11] = {rsc_pkg::RSC_WITHIN, 2'h3, 20'h4_93E0, 3'h5, rsc_pkg::RSC_ST_ON};
    rows[12] = {rsc_pkg::RSC_WITHIN, 2'h3, 20'h4_93E0, 3'h0, rsc_pkg::RSC_ST_CLEAR};
    rows[13] = {rsc_pkg::RSC_WITHIN, 2'h3, 20'h5_3020, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[14] = {rsc_pkg::RSC_ON, 2'h0, 20'h4_93E0, 3'h5, rsc_pkg::RSC_ST_ON};
    rows[15] = {rsc_pkg::RSC_OFF, 2'h3, 20'h5_3020, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    rows[16] = {rsc_pkg::RSC_CTRL, 2'h0, 20'h4_93E0, 3'h7, rsc_pkg::RSC_ST_ON};
    rows[17] = {rsc_pkg::RSC_CTRL, 2'h0, 20'h4_93E0, 3'h4, rsc_pkg::RSC_ST_CLEAR};
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values
    rd(rsc_pkg::OFF_DEADBAND);
    `CHK("deadband", 32'h0000_00FA, rd_q)
    rd(rsc_pkg::OFF_CFG1);
    `CHK("cfg1", 32'h0000_0100, rd_q)
    rd(8'h3C);
    `CHK("unmapped", 32'h0000_0000, rd_q)
    wr(rsc_pkg::OFF_HIGH0, 32'h0005_0910);
    wr(rsc_pkg::OFF_LOW0, 32'h0003_D090);
    // table of mode and threshold cases on relay 0
    foreach (rows[i])
    begin
      wr(rsc_pkg::OFF_CFG0, {26'h0, rows[i].en, 1'b0, rows[i].mode});
      temp_valid[0] <= rows[i].vld;
      ctrl_active <= rows[i].ctl;
      sample(0, rows[i].temp);
      `CHK("relay0", rows[i].rly, relay_out[0])
      `CHK("led0", rows[i].rly, relay_led[0])
      `CHK("engaged0", rows[i].rly, engaged[0])
      rd(rsc_pkg::OFF_STATUS);
      `CHK("status0", rows[i].st, rd_q[1:0])
    end
    temp_valid <= 8'hFF;
    // relay 1 on its own source, independent of relay 0
    wr(rsc_pkg::OFF_HIGH1, 32'h0000_2710);
    wr(rsc_pkg::OFF_CFG1, 32'h0000_0312);
    sample(3, 20'h0_4E20);
    `CHK("relays", 2'h2, relay_out)
    rd(rsc_pkg::OFF_STATUS);
    `CHK("status1", 2'h1, rd_q[3:2])
    // disabled limit ignored although reading still out of range
    wr(rsc_pkg::OFF_CFG1, 32'h0000_0302);
    sample(3, 20'h0_4E20);
    `CHK("relay1_dis", 1'b0, relay_out[1])
    // interrupt on relay 0 rise: raise, mask, clear
    wr(rsc_pkg::OFF_IRQ_STAT, 32'h0000_000F);
    wr(rsc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(rsc_pkg::OFF_CFG0, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    #1 `CHK("irq_rise", 1'b1, irq)
    wr(rsc_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    #1 `CHK("irq_masked", 1'b0, irq)
    wr(rsc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(rsc_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    #1 `CHK("irq_clear", 1'b0, irq)
    wr(rsc_pkg::OFF_CFG0, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    rd(rsc_pkg::OFF_IRQ_STAT);
    `CHK("irq_fall", 32'h0000_0004, rd_q)
    `CHK("irq_fall_masked", 1'b0, irq)
    // reset in mid-run while relay 0 is held on
    wr(rsc_pkg::OFF_CFG0, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b0;
    #1 `CHK("rst_relay", 2'h0, relay_out)
    `CHK("rst_irq", 1'b0, irq)
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(rsc_pkg::OFF_CFG0);
    `CHK("rst_cfg0", 32'h0000_0000, rd_q)
    // spare mode codes act as off
    wr(rsc_pkg::OFF_CFG0, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    wr(rsc_pkg::OFF_CFG0, 32'h0000_0005);
    repeat (3) @(posedge ref_clk);
    #1 `CHK("spare_mode", 1'b0, relay_out[0])
    report_and_stop();
  end
endmodule
`default_nettype wire
